// [inc/aala_cfg.svh]
`ifndef AALA_CFG_SVH
`define AALA_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AALA_OFS_CMD     12'h000
`define AALA_OFS_WREG    12'h004
`define AALA_OFS_FLAGS   12'h008
`define AALA_OFS_RESULT  12'h00C
`define AALA_OFS_MEM     12'h040
`define AALA_MEM_MASK    12'hFC0
`define AALA_MEM_IDX     5:2
`define AALA_ADR_LSB     1:0
`define AALA_ADDR_W      12

// ----------------------------------------
// Command word fields
// ----------------------------------------
`define AALA_CMD_OP      2:0
`define AALA_CMD_ADR     11:8
`define AALA_CMD_IMM     23:16
`define AALA_OP_NONE     3'h0
`define AALA_OP_ADD_TO_MEMORY     3'h1
`define AALA_OP_ANDA     3'h2
`define AALA_OP_ANDI     3'h3
`define AALA_OP_AND_TO_MEMORY     3'h4

// ----------------------------------------
// Flag bits and sizes
// ----------------------------------------
`define AALA_FLG_BITOUT  0
`define AALA_FLG_NIBBLE  1
`define AALA_FLG_NULL    2
`define AALA_FLG_SIGNED  3
`define AALA_FLG_W       4
`define AALA_MEM_DEPTH   16
`define AALA_RESP_OKAY   2'h0
`define AALA_RESP_SLVERR 2'h2

`endif

// [inc/aala_pkg.sv]
`include "aala_cfg.svh"

package aala_pkg;
  typedef logic [2:0]                  aala_op_t;
  typedef logic [3:0]                  aala_adr_t;
  typedef logic [`AALA_FLG_W-1:0]      aala_flags_t;
  typedef enum logic [2:0] {
    AALA_SEL_CMD,
    AALA_SEL_WREG,
    AALA_SEL_FLAGS,
    AALA_SEL_RESULT,
    AALA_SEL_MEM,
    AALA_SEL_NONE
  } aala_sel_e;
endpackage : aala_pkg

// [verilog/aala_core.sv]
// Overview of operation
// [RULE1] Add working register into memory byte
// [RULE2] Add updates range, null, nibble, bit flags
// [RULE3] AND memory into working register, null flag
// [RULE4] AND immediate into working register, null flag
// [RULE5] AND working register into memory byte
// [RULE6] Memory AND keeps register, null flag only
//
// Our own choices: register access over AXI4-Lite and the address map.
`include "aala_cfg.svh"

module aala_core
  import aala_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // AXI4-Lite write address
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // AXI4-Lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read address
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // AXI4-Lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Datapath state
  output logic [7:0]       workingRegister,
  output aala_flags_t      flags
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic aala_sel_e regSel(input logic [`AALA_ADDR_W-1:0] a);
    if (a == `AALA_OFS_CMD) begin
      regSel = AALA_SEL_CMD;
    end else if (a == `AALA_OFS_WREG) begin
      regSel = AALA_SEL_WREG;
    end else if (a == `AALA_OFS_FLAGS) begin
      regSel = AALA_SEL_FLAGS;
    end else if (a == `AALA_OFS_RESULT) begin
      regSel = AALA_SEL_RESULT;
    end else if ((a & `AALA_MEM_MASK) == `AALA_OFS_MEM && a[`AALA_ADR_LSB] == 2'h0) begin
      regSel = AALA_SEL_MEM;
    end else begin
      regSel = AALA_SEL_NONE;
    end
  endfunction : regSel

  function automatic aala_adr_t memIdx(input logic [`AALA_ADDR_W-1:0] a);
    memIdx = a[`AALA_MEM_IDX];
  endfunction : memIdx

  function automatic logic selHit(input aala_sel_e s, input aala_sel_e t, input logic go);
    selHit = go & (s == t);
  endfunction : selHit

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0]               mem [`AALA_MEM_DEPTH];
  logic                     awHeld;
  logic                     wHeld;
  logic [`AALA_ADDR_W-1:0]  awAddrQ;
  logic [31:0]              wDataQ;
  logic [3:0]               wStrbQ;
  logic [31:0]              lastCmd;
  logic [7:0]               lastResult;

  // ----------------------------------------
  // Write channel handshakes
  // ----------------------------------------
  wire awTake = awvalid & awready;
  wire wTake  = wvalid & wready;
  wire doWrite = awHeld & wHeld & ~bvalid;
  wire next_awHeld = doWrite ? 1'b0 : (awHeld | awTake);
  wire next_wHeld  = doWrite ? 1'b0 : (wHeld | wTake);

  wire aala_sel_e wSel = regSel(awAddrQ);
  wire            wLow = wStrbQ[0];
  wire            wMapped = (wSel != AALA_SEL_NONE);

  // ----------------------------------------
  // Bus register selects
  // ----------------------------------------
  wire busGo   = doWrite & wLow;
  wire wrCmd   = selHit(wSel, AALA_SEL_CMD, busGo);
  wire wrWreg  = selHit(wSel, AALA_SEL_WREG, busGo);
  wire wrFlags = selHit(wSel, AALA_SEL_FLAGS, busGo);
  wire wrMem   = selHit(wSel, AALA_SEL_MEM, busGo);

  // ----------------------------------------
  // Command decode and datapath
  // ----------------------------------------
  wire       cmdWrite = wrCmd;
  wire [2:0] cmdOp    = wDataQ[`AALA_CMD_OP];
  wire [3:0] cmdAdr   = wDataQ[`AALA_CMD_ADR];
  wire [7:0] cmdImm   = wDataQ[`AALA_CMD_IMM];
  wire [7:0] memOp    = mem[cmdAdr];

  wire [8:0] sumFull  = {1'b0, workingRegister} + {1'b0, memOp};
  wire [4:0] sumNib   = {1'b0, workingRegister[3:0]} + {1'b0, memOp[3:0]};
  wire [7:0] sum      = sumFull[7:0];
  wire       sumRange = (workingRegister[7] == memOp[7]) & (sum[7] != workingRegister[7]);
  wire [7:0] andMem   = workingRegister & memOp;
  wire [7:0] andImm   = workingRegister & cmdImm;

  wire isAddm = cmdWrite & (cmdOp == `AALA_OP_ADD_TO_MEMORY);
  wire isAnda = cmdWrite & (cmdOp == `AALA_OP_ANDA);
  wire isAndi = cmdWrite & (cmdOp == `AALA_OP_ANDI);
  wire isAndm = cmdWrite & (cmdOp == `AALA_OP_AND_TO_MEMORY);

  // Result of the executed command
  wire [7:0] opResult = isAddm ? sum :
                        isAndi ? andImm :
                        andMem;
  wire       opValid  = isAddm | isAnda | isAndi | isAndm;

  // Memory write port
  wire       memFromOp  = isAddm | isAndm;
  wire       memFromBus = wrMem;
  wire [3:0] memWrAdr   = memFromOp ? cmdAdr : memIdx(awAddrQ);
  wire [7:0] memWrDat   = memFromOp ? opResult : wDataQ[7:0];

  // Working register next value
  wire [7:0] next_workingRegister =
    (isAnda | isAndi) ? opResult :                          // [RULE3] [RULE4]
    wrWreg ? wDataQ[7:0] :
    workingRegister;                                         // [RULE6]

  // Flag next value
  wire nullBit = (opResult == 8'h00);
  aala_flags_t addFlags;
  aala_flags_t andFlags;
  aala_flags_t next_flags;
  always_comb begin
    addFlags = flags;
    addFlags[`AALA_FLG_BITOUT] = sumFull[8];                 // [RULE2]
    addFlags[`AALA_FLG_NIBBLE] = sumNib[4];                  // [RULE2]
    addFlags[`AALA_FLG_NULL]   = nullBit;                    // [RULE2]
    addFlags[`AALA_FLG_SIGNED] = sumRange;                   // [RULE2]
    andFlags = flags;
    andFlags[`AALA_FLG_NULL]   = nullBit;                    // [RULE3] [RULE4] [RULE6]
    if (isAddm) begin
      next_flags = addFlags;
    end else if (isAnda | isAndi | isAndm) begin
      next_flags = andFlags;
    end else if (wrFlags) begin
      next_flags = wDataQ[`AALA_FLG_W-1:0];
    end else begin
      next_flags = flags;
    end
  end

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  wire [`AALA_ADDR_W-1:0] rAddr = araddr[`AALA_ADDR_W-1:0];
  wire aala_sel_e rSel = regSel(rAddr);
  wire [7:0]      rMem = mem[memIdx(rAddr)];
  wire [31:0] readWord = (rSel == AALA_SEL_CMD)    ? lastCmd :
                         (rSel == AALA_SEL_WREG)   ? {24'h000000, workingRegister} :
                         (rSel == AALA_SEL_FLAGS)  ? {28'h0000000, flags} :
                         (rSel == AALA_SEL_RESULT) ? {24'h000000, lastResult} :
                         (rSel == AALA_SEL_MEM)    ? {24'h000000, rMem} :
                         32'h00000000;
  wire [1:0] readResp = (rSel == AALA_SEL_NONE) ? `AALA_RESP_SLVERR : `AALA_RESP_OKAY;
  wire       arTake   = arvalid & arready;

  // ----------------------------------------
  // Write path registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awHeld  <= 1'b0;
      wHeld   <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
    end else begin
      awHeld  <= next_awHeld;
      wHeld   <= next_wHeld;
      awready <= ~next_awHeld & ~awTake;
      wready  <= ~next_wHeld & ~wTake;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awAddrQ <= `AALA_OFS_CMD;
    end else if (awTake) begin
      awAddrQ <= awaddr[`AALA_ADDR_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wDataQ <= 32'h00000000;
      wStrbQ <= 4'h0;
    end else if (wTake) begin
      wDataQ <= wdata;
      wStrbQ <= wstrb;
    end
  end

  // ----------------------------------------
  // Write response registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bvalid <= 1'b0;
    end else if (doWrite) begin
      bvalid <= 1'b1;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bresp <= `AALA_RESP_OKAY;
    end else if (doWrite) begin
      bresp <= wMapped ? `AALA_RESP_OKAY : `AALA_RESP_SLVERR;
    end
  end

  // ----------------------------------------
  // Datapath registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      workingRegister <= 8'h00;
    end else begin
      workingRegister <= next_workingRegister;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lastCmd <= 32'h00000000;
    end else if (cmdWrite) begin
      lastCmd <= wDataQ;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lastResult <= 8'h00;
    end else if (opValid) begin
      lastResult <= opResult;
    end
  end

  // Sum or AND result, or bus write data, into memory
  always_ff @(posedge ref_clk) begin
    if (memFromOp | memFromBus) begin
      mem[memWrAdr] <= memWrDat;                             // [RULE1] [RULE5]
    end
  end

  // ----------------------------------------
  // Read path registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      arready <= 1'b0;
    end else if (arTake) begin
      arready <= 1'b0;
    end else if (~rvalid | rready) begin
      arready <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `AALA_RESP_OKAY;
    end else if (arTake) begin
      rvalid <= 1'b1;
      rdata  <= readWord;
      rresp  <= readResp;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule : aala_core

// [tb/aala_axi_master.sv]
module aala_axi_master (
  // Clock
  input  wire logic        ref_clk,
  // Write
  output logic [31:0]      awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // Read
  output logic [31:0]      araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hF;
  end
  task automatic wr(input logic [31:0] a, d, output logic [1:0] r, input logic [3:0] s = 4'hF);
    r = 2'h3;
    awaddr  <= a;
    wstrb   <= s;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    repeat (50) begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
    bready <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    r = 2'h3;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    repeat (50) begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask : rd
endmodule : aala_axi_master

// [tb/aala_core_checker.sv]
`include "aala_cfg.svh"

module aala_core_checker
  import aala_pkg::*;
(
  // Clock, reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Write
  input wire logic [31:0] awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  input wire logic        wvalid,
  input wire logic        wready,
  // Datapath
  input wire logic [7:0]  workingRegister,
  input wire aala_flags_t flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] imm;
  wire        take = awvalid && awready && wvalid && wready && wstrb[0] && awaddr[11:0] == `AALA_OFS_CMD;
  wire [2:0]  op   = take ? wdata[`AALA_CMD_OP] : `AALA_OP_NONE;
  wire        wr0  = workingRegister == 8'h00;
  always_ff @(posedge ref_clk) if (take) imm <= wdata[`AALA_CMD_IMM];
  a_add_to_memory_wreg: assert property (op == `AALA_OP_ADD_TO_MEMORY |=> ##1 $stable(workingRegister))
    else $error("add changed register");
  a_add_to_memory_flags: assert property (op == `AALA_OP_ADD_TO_MEMORY && wr0 |=> ##1 (flags & 4'hB) == 4'h0)
    else $error("add of zero set flags");
  a_anda_null: assert property (op == `AALA_OP_ANDA |=> ##1 $stable(flags & 4'hB) && flags[`AALA_FLG_NULL] == wr0)
    else $error("memory AND flags wrong");
  a_andi_res: assert property (op == `AALA_OP_ANDI |=> ##1 workingRegister == ($past(workingRegister) & imm))
    else $error("immediate AND wrong");
  a_and_to_memory_null: assert property (op == `AALA_OP_AND_TO_MEMORY && wr0 |=> ##1 flags[`AALA_FLG_NULL])
    else $error("null flag clear");
  a_and_to_memory_keep: assert property (op == `AALA_OP_AND_TO_MEMORY |=> ##1 $stable(workingRegister) && $stable(flags & 4'hB))
    else $error("register changed");
  c_add_to_memory: cover property (op == `AALA_OP_ADD_TO_MEMORY);
  c_andi: cover property (op == `AALA_OP_ANDI);
  c_and_to_memory: cover property (op == `AALA_OP_AND_TO_MEMORY);
endmodule : aala_core_checker

bind aala_core aala_core_checker u_chk (.ref_clk(ref_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
  .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
  .workingRegister(workingRegister),
  .flags(flags));

// [tb/tb_accumulator_add_and_logic.sv]
`include "aala_cfg.svh"
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin failCount++; $display("Error at %0t: got %h want %h", $time, a, e); end end

module tb_accumulator_add_and_logic
  import aala_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0]  ok  = `AALA_RESP_OKAY;
  localparam logic [11:0] top = `AALA_OFS_MEM + 12'h03C;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  workingRegister;
  aala_flags_t flags;
  int          failCount  = 0;
  int          checksDone = 0;
  aala_core i_dut (
    .ref_clk(ref_clk), .rst(rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .workingRegister(workingRegister), .flags(flags)
  );
  aala_axi_master i_mst (
    .ref_clk(ref_clk),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );
  always #20 ref_clk = ~ref_clk;
  task automatic conclude;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  task automatic xfer(input logic isRd, input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0]  r;
    if (isRd) i_mst.rd({20'h0, a}, q, r);
    else i_mst.wr({20'h0, a}, d, r);
    if (r === 2'h3) begin
      failCount++;
      conclude();
    end
    `CHK(r, er)
    if (isRd) `CHK(q, d)
  endtask : xfer
  task automatic run(input aala_op_t o, input logic [7:0] w, m, x, input aala_flags_t f,
                     input logic [7:0] ew, em, input aala_flags_t ef);
    xfer(1'b0, `AALA_OFS_WREG, {24'h0, w}, ok);
    xfer(1'b0, `AALA_OFS_FLAGS, {28'h0, f}, ok);
    xfer(1'b0, top, {24'h0, m}, ok);
    xfer(1'b0, `AALA_OFS_CMD, {8'h0, x, 8'h0F, 5'h0, o}, ok);
    `CHK(workingRegister, ew)
    `CHK(flags, ef)
    xfer(1'b1, top, {24'h0, em}, ok);
  endtask : run
  task automatic t_add_to_memory;
    aala_op_t o = `AALA_OP_ADD_TO_MEMORY;
    run(o, 8'h00, 8'h00, 8'h00, 4'hB, 8'h00, 8'h00, 4'h4);
    run(o, 8'h7F, 8'h01, 8'h00, 4'h5, 8'h7F, 8'h80, 4'hA);
    run(o, 8'hFF, 8'h01, 8'h00, 4'h8, 8'hFF, 8'h00, 4'h7);
    run(o, 8'h80, 8'h80, 8'h00, 4'h2, 8'h80, 8'h00, 4'hD);
    run(o, 8'h12, 8'h34, 8'h00, 4'hF, 8'h12, 8'h46, 4'h0);
    $display("t_add_to_memory done");
  endtask : t_add_to_memory
  task automatic t_and;
    run(`AALA_OP_ANDA, 8'hCC, 8'hAA, 8'h00, 4'hF, 8'h88, 8'hAA, 4'hB);
    run(`AALA_OP_ANDA, 8'h0F, 8'hF0, 8'h00, 4'h0, 8'h00, 8'hF0, 4'h4);
    run(`AALA_OP_ANDI, 8'h3C, 8'h55, 8'hA5, 4'hF, 8'h24, 8'h55, 4'hB);
    run(`AALA_OP_ANDI, 8'hF0, 8'hFF, 8'h0F, 4'h8, 8'h00, 8'hFF, 4'hC);
    $display("t_and done");
  endtask : t_and
  task automatic t_and_to_memory;
    run(`AALA_OP_AND_TO_MEMORY, 8'h00, 8'h5A, 8'h00, 4'hB, 8'h00, 8'h00, 4'hF);
    run(`AALA_OP_AND_TO_MEMORY, 8'h3C, 8'hF3, 8'h00, 4'h4, 8'h3C, 8'h30, 4'h0);
    xfer(1'b1, `AALA_OFS_RESULT, 32'h00000030, ok);
    xfer(1'b1, `AALA_OFS_CMD, 32'h00000F04, ok);
    $display("t_and_to_memory done");
  endtask : t_and_to_memory
  task automatic t_bus;
    logic [1:0] r;
    `CHK(workingRegister, 8'h00)
    `CHK(flags, 4'h0)
    xfer(1'b0, 12'h080, 32'h0, `AALA_RESP_SLVERR);
    xfer(1'b1, 12'h080, 32'h0, `AALA_RESP_SLVERR);
    run(3'h5, 8'h11, 8'h22, 8'h33, 4'h9, 8'h11, 8'h22, 4'h9);
    xfer(1'b1, `AALA_OFS_CMD, 32'h00330F05, ok);
    xfer(1'b1, `AALA_OFS_RESULT, 32'h00000000, ok);
    i_mst.wr({20'h0, `AALA_OFS_WREG}, 32'h000000EE, r, 4'h0);
    `CHK(r, ok)
    xfer(1'b1, `AALA_OFS_WREG, 32'h11, ok);
    $display("t_bus done");
  endtask : t_bus
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_bus;
    t_add_to_memory;
    t_and;
    t_and_to_memory;
    conclude();
  end
endmodule : tb_accumulator_add_and_logic
